/* File: srgt_pkg.sv */
package srgt_pkg;
  // clock
  localparam int unsigned CLK_HZ = 50_000_000;
  // times as printed
  localparam int unsigned FAST_LIMIT_FULL_US = 800;
  localparam int unsigned FAST_LIMIT_PART_US = 3200;
  localparam int unsigned RESTART_WAIT_MS = 50;
  localparam int unsigned DIR_OFF_US = 100;
  localparam int unsigned DEAD_US = 1;
  // cycle counts (all exact at 50 MHz, no rounding)
  localparam int unsigned FAST_LIMIT_FULL_CYC = FAST_LIMIT_FULL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FAST_LIMIT_PART_CYC = FAST_LIMIT_PART_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RESTART_WAIT_CYC = RESTART_WAIT_MS * (CLK_HZ / 1_000);
  localparam int unsigned DIR_OFF_CYC = DIR_OFF_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DEAD_CYC = DEAD_US * (CLK_HZ / 1_000_000);
  // counts
  localparam int unsigned SHORT_RUN_COUNT = 16;
  localparam int unsigned FAIL_LIMIT = 8;
  localparam int unsigned FAIL_WINDOW_PERIODS = 2;
  localparam int unsigned FG_RELEASE_DEG = 480;
  localparam int unsigned DEG_PER_STEP = 60;
  localparam int unsigned FG_RELEASE_STEPS = FG_RELEASE_DEG / DEG_PER_STEP + 1;
  // reset values
  localparam logic [2:0] PHASE_RESET = 3'h0;

  // one half-bridge drive request per phase
  typedef struct packed {
    logic [2:0] high_on;
    logic [2:0] low_on;
  } srgt_bridge_s;

  typedef enum logic [4:0] {
    SRGT_IDLE = 5'h01,
    SRGT_START = 5'h02,
    SRGT_RUN = 5'h04,
    SRGT_WAIT = 5'h08,
    SRGT_HALT = 5'h10
  } srgt_state_e;
endpackage

/* File: srgt_core.sv */
`timescale 1ns/100ps
// Operation
// - chop only low-side gates; high-side gates never follow the chop signal
// - restart supervision runs only with analogue speed command selected
// - full duty: sixteen feedback periods at most 800 us declare fast loss
// - partial duty: sixteen feedback periods at most 3.2 ms declare fast loss
// - after fast loss wait 50 ms, then start afresh
// - no feedback edge within two forced periods after excitation means failed start
// - after failed start wait 50 ms, then repeat start-up
// - eighth consecutive failed start latches halt, no more restarts
// - halt latch clears on disable high or power-up reset
// - direction change holds all six transistors off for 100 us
// - high/low switch of a bridge inserts 1 us with both off
// - feedback low when stopped or forced; follows U after 480 degrees normal
module srgt_core #(
  parameter int unsigned RESTART_WAIT = srgt_pkg::RESTART_WAIT_CYC,
  parameter int unsigned DIR_OFF = srgt_pkg::DIR_OFF_CYC,
  parameter int unsigned DEAD = srgt_pkg::DEAD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // commands
  input wire logic disable_input,
  input wire logic direction_select,
  input wire logic analog_speed_command,
  input wire logic run_request,
  // sequencer side
  input wire logic internal_chop_signal,
  input wire logic chop_full_duty,
  input wire srgt_pkg::srgt_bridge_s commutation,
  input wire logic forced_mode,
  input wire logic forced_step,
  input wire logic excitation_done,
  input wire logic position_u,
  input wire logic position_step,
  // status to sequencer
  output logic start_request,
  output logic motor_halted,
  // gate outputs and rotation feedback
  output logic high_gate_u,
  output logic high_gate_v,
  output logic high_gate_w,
  output logic low_gate_u,
  output logic low_gate_v,
  output logic low_gate_w,
  output logic rotation_feedback
);
  import srgt_pkg::*;

  // counters below are 8, 13 and 23 bits wide
  if (DEAD < 1 || DEAD > 255 || DIR_OFF < 1 || DIR_OFF > 8191
      || RESTART_WAIT < 1 || RESTART_WAIT > 8388608) begin : g_bad_param
    $error("srgt_core: count parameter out of range");
  end

  srgt_state_e state_reg, state_next;
  logic [22:0] wait_cnt_reg;
  logic [17:0] period_cnt_reg;
  logic [4:0] short_cnt_reg;
  logic [3:0] fail_cnt_reg;
  logic [1:0] forced_cnt_reg;
  logic [3:0] norm_steps_reg;
  logic fg_prev_reg;
  logic fg_edge;
  logic period_short;
  logic fast_loss;
  logic start_fail;
  logic supervise;
  logic wait_done;
  logic [17:0] period_limit;

  assign supervise = analog_speed_command & run_request;
  assign fg_edge = rotation_feedback & ~fg_prev_reg;
  assign period_limit = chop_full_duty ? 18'(FAST_LIMIT_FULL_CYC) : 18'(FAST_LIMIT_PART_CYC);
  // counter holds period length minus one at the closing edge
  assign period_short = period_cnt_reg < period_limit;
  assign fast_loss = supervise && state_reg == SRGT_RUN && fg_edge && period_short
    && short_cnt_reg == 5'(SHORT_RUN_COUNT - 1);
  assign start_fail = supervise && state_reg == SRGT_START && forced_step
    && forced_cnt_reg == 2'(FAIL_WINDOW_PERIODS - 1) && !fg_edge;
  assign wait_done = wait_cnt_reg == 23'(RESTART_WAIT - 1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SRGT_IDLE: begin
        if (run_request) begin
          state_next = SRGT_START;
        end
      end
      SRGT_START: begin
        if (start_fail) begin
          state_next = (fail_cnt_reg == 4'(FAIL_LIMIT - 1)) ? SRGT_HALT : SRGT_WAIT;
        end else if (!forced_mode) begin
          state_next = SRGT_RUN;
        end
      end
      SRGT_RUN: begin
        if (fast_loss) begin
          state_next = SRGT_WAIT;
        end else if (forced_mode) begin
          state_next = SRGT_START;
        end
      end
      SRGT_WAIT: begin
        if (wait_done) begin
          state_next = SRGT_START;
        end
      end
      SRGT_HALT: begin
        state_next = SRGT_HALT;
      end
      default: begin
        state_next = SRGT_IDLE;
      end
    endcase
    if (disable_input) begin
      state_next = SRGT_IDLE;
    end else if (!run_request && state_reg != SRGT_HALT) begin
      state_next = SRGT_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= SRGT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_reg != SRGT_WAIT) begin
      wait_cnt_reg <= '0;
    end else if (!wait_done) begin
      wait_cnt_reg <= wait_cnt_reg + 23'h000001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fail_cnt_reg <= 4'h0;
    end else if (disable_input || (state_reg == SRGT_START && state_next == SRGT_RUN)) begin
      fail_cnt_reg <= 4'h0;
    end else if (start_fail && fail_cnt_reg != 4'(FAIL_LIMIT)) begin
      fail_cnt_reg <= fail_cnt_reg + 4'h1;
    end
  end

  // forced periods counted only after excitation has finished
  always_ff @(posedge clk) begin
    if (reset || state_reg != SRGT_START || !excitation_done || fg_edge) begin
      forced_cnt_reg <= 2'h0;
    end else if (forced_step && forced_cnt_reg != 2'(FAIL_WINDOW_PERIODS - 1)) begin
      forced_cnt_reg <= forced_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    // no edge seen yet: first edge closes no period, so treat it as long
    if (reset || state_reg != SRGT_RUN) begin
      period_cnt_reg <= 18'h3FFFF;
    end else if (fg_edge) begin
      period_cnt_reg <= 18'h00000;
    end else if (period_cnt_reg != 18'h3FFFF) begin
      period_cnt_reg <= period_cnt_reg + 18'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_reg != SRGT_RUN) begin
      short_cnt_reg <= 5'h00;
    end else if (fg_edge) begin
      short_cnt_reg <= period_short ? short_cnt_reg + 5'h01 : 5'h00;
    end
  end

  // feedback released after 480 degrees of normal commutation
  always_ff @(posedge clk) begin
    if (reset || state_reg != SRGT_RUN || forced_mode) begin
      norm_steps_reg <= 4'h0;
      rotation_feedback <= 1'b0;
    end else begin
      if (position_step && norm_steps_reg != 4'(FG_RELEASE_STEPS)) begin
        norm_steps_reg <= norm_steps_reg + 4'h1;
      end
      rotation_feedback <= (norm_steps_reg == 4'(FG_RELEASE_STEPS)) ? position_u : 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fg_prev_reg <= 1'b0;
    end else begin
      fg_prev_reg <= rotation_feedback;
    end
  end

  assign start_request = state_reg == SRGT_START;
  assign motor_halted = state_reg == SRGT_HALT;

  // direction change blanking
  logic dir_prev_reg;
  logic [12:0] dir_cnt_reg;
  logic dir_blank;
  always_ff @(posedge clk) begin
    if (reset) begin
      dir_prev_reg <= 1'b0;
      dir_cnt_reg <= 13'h0000;
    end else begin
      dir_prev_reg <= direction_select;
      if (dir_prev_reg != direction_select) begin
        dir_cnt_reg <= 13'(DIR_OFF);
      end else if (dir_cnt_reg != 13'h0000) begin
        dir_cnt_reg <= dir_cnt_reg - 13'h0001;
      end
    end
  end
  assign dir_blank = dir_cnt_reg != 13'h0000 || dir_prev_reg != direction_select;

  logic drive_ok;
  assign drive_ok = (state_reg == SRGT_START || state_reg == SRGT_RUN) && !dir_blank;

  // per-bridge dead time: a side turns on only after both were off for DEAD cycles
  logic [2:0] high_q, low_q;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_bridge
      logic want_hi, want_lo;
      logic [7:0] dead_cnt_reg;
      assign want_hi = drive_ok && commutation.high_on[g] && !commutation.low_on[g];
      // chop only on the low side, high side is a steady level
      assign want_lo = drive_ok && commutation.low_on[g] && !commutation.high_on[g]
        && internal_chop_signal;
      always_ff @(posedge clk) begin
        if (reset) begin
          high_q[g] <= 1'b0;
          low_q[g] <= 1'b0;
          dead_cnt_reg <= 8'h00;
        end else if ((high_q[g] && !want_hi) || (low_q[g] && !want_lo)) begin
          high_q[g] <= high_q[g] & want_hi;
          low_q[g] <= low_q[g] & want_lo;
          dead_cnt_reg <= 8'(DEAD);
        end else if (dead_cnt_reg != 8'h00) begin
          dead_cnt_reg <= dead_cnt_reg - 8'h01;
        end else begin
          high_q[g] <= want_hi;
          low_q[g] <= want_lo && !want_hi;
        end
      end
      property p_no_shoot;
        @(posedge clk) disable iff (reset)
          !(high_q[g] && low_q[g]);
      endproperty
      a_no_shoot: assert property (p_no_shoot) else $error("both transistors on");
    end
  endgenerate

  // high-side gates are active low (p-channel)
  always_ff @(posedge clk) begin
    if (reset) begin
      {high_gate_u, high_gate_v, high_gate_w} <= 3'h7;
      {low_gate_u, low_gate_v, low_gate_w} <= PHASE_RESET;
    end else begin
      {high_gate_w, high_gate_v, high_gate_u} <= ~high_q;
      {low_gate_w, low_gate_v, low_gate_u} <= low_q;
    end
  end

  property p_fast_loss_wait;
    @(posedge clk) disable iff (reset || disable_input || !run_request)
      fast_loss |=> state_reg == SRGT_WAIT;
  endproperty
  a_fast_loss_wait: assert property (p_fast_loss_wait) else $error("fast loss not handled");

  property p_supervise_only_analog;
    @(posedge clk) disable iff (reset)
      !analog_speed_command |-> !fast_loss && !start_fail;
  endproperty
  a_supervise_only_analog: assert property (p_supervise_only_analog) else $error("supervision active");

  property p_halt_latched;
    @(posedge clk) disable iff (reset)
      motor_halted && !disable_input |=> motor_halted;
  endproperty
  a_halt_latched: assert property (p_halt_latched) else $error("halt left");

  property p_disable_clears;
    @(posedge clk) disable iff (reset)
      disable_input |=> !motor_halted && fail_cnt_reg == 4'h0;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("halt not cleared");

  property p_dir_off;
    @(posedge clk) disable iff (reset)
      $changed(direction_select) |=> ##1 (low_q == 3'h0 && high_q == 3'h0)[*8];
  endproperty
  a_dir_off: assert property (p_dir_off) else $error("gates on after direction change");

  property p_fg_low_stopped;
    @(posedge clk) disable iff (reset)
      state_reg != SRGT_RUN |=> !rotation_feedback;
  endproperty
  a_fg_low_stopped: assert property (p_fg_low_stopped) else $error("feedback while stopped");

  property p_high_no_chop;
    @(posedge clk) disable iff (reset)
      $stable(commutation) && $stable(drive_ok) && high_q != 3'h0 && $fell(internal_chop_signal)
        |=> (high_q & $past(high_q)) == $past(high_q);
  endproperty
  a_high_no_chop: assert property (p_high_no_chop) else $error("high side chopped");

  property p_long_clears;
    @(posedge clk) disable iff (reset)
      state_reg == SRGT_RUN && fg_edge && !period_short && state_next == SRGT_RUN |=> short_cnt_reg == 5'h00;
  endproperty
  a_long_clears: assert property (p_long_clears) else $error("short run not cleared");

  property p_fail_wait;
    @(posedge clk) disable iff (reset || disable_input || !run_request)
      start_fail && fail_cnt_reg < 4'(FAIL_LIMIT - 1) |=> state_reg == SRGT_WAIT;
  endproperty
  a_fail_wait: assert property (p_fail_wait) else $error("failed start not waited");
endmodule // srgt_core

/* File: srgt_bridge_model.sv */
`timescale 1ns/100ps
// three half bridges; counts shoot-through and short dead time per leg
module srgt_bridge_model #(
  parameter int unsigned DEAD = 3
) (
  // clock
  input wire logic clk,
  // gate drive
  input wire logic [2:0] high_gate_n,
  input wire logic [2:0] low_gate,
  // fault tally
  output int faults
);
  logic [2:0] was_high;
  // large start value so the first conduction is never flagged
  int off_cnt [3] = '{1000, 1000, 1000};

  initial faults = 0;

  always @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (!high_gate_n[i] && low_gate[i]) faults++;
      if (!high_gate_n[i] || low_gate[i]) begin
        if (off_cnt[i] < DEAD && was_high[i] !== !high_gate_n[i]) faults++;
        was_high[i] = !high_gate_n[i];
        off_cnt[i] = 0;
      end else off_cnt[i]++;
    end
  end
endmodule // srgt_bridge_model

/* File: srgt_core_tb_top.sv */
`timescale 1ns/100ps
module srgt_core_tb_top;
  import srgt_pkg::*;
  localparam int unsigned RW = 100;
  localparam int unsigned DOFF = 20;
  localparam int unsigned DT = 3;
  // two long periods of about 40k cycles dominate the run
  localparam int unsigned CEIL = 95000;
  logic clk = 0;
  logic reset = 1;
  logic disable_input = 0;
  logic direction_select = 0;
  logic analog_speed_command = 0;
  logic run_request = 0;
  logic internal_chop_signal = 0;
  logic chop_full_duty = 1;
  srgt_bridge_s commutation = '0;
  logic forced_mode = 1;
  logic forced_step = 0;
  logic excitation_done = 0;
  logic position_u = 0;
  logic position_step = 0;
  logic start_request;
  logic motor_halted;
  logic rotation_feedback;
  wire [2:0] hg;
  wire [2:0] lg;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int faults;
  logic [7:0] rnd = 8'h5C;

  srgt_core #(.RESTART_WAIT(RW), .DIR_OFF(DOFF), .DEAD(DT)) u_dut (
    .clk(clk), .reset(reset), .disable_input(disable_input), .direction_select(direction_select),
    .analog_speed_command(analog_speed_command), .run_request(run_request),
    .internal_chop_signal(internal_chop_signal), .chop_full_duty(chop_full_duty),
    .commutation(commutation), .forced_mode(forced_mode), .forced_step(forced_step),
    .excitation_done(excitation_done), .position_u(position_u), .position_step(position_step),
    .start_request(start_request), .motor_halted(motor_halted),
    .high_gate_u(hg[0]), .high_gate_v(hg[1]), .high_gate_w(hg[2]),
    .low_gate_u(lg[0]), .low_gate_v(lg[1]), .low_gate_w(lg[2]), .rotation_feedback(rotation_feedback)
  );

  srgt_bridge_model #(.DEAD(DT)) u_bridge (.clk(clk), .high_gate_n(hg), .low_gate(lg), .faults(faults));

  initial begin
    forever #10 clk = ~clk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic all_off();
    return hg === 3'h7 && lg === 3'h0;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == CEIL) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic wait_start(input int lo, input int hi);
    int n;
    n = 0;
    while (start_request !== 1'b1 && n <= hi) begin
      step(1);
      n++;
    end
    check(n >= lo && n <= hi, 1);
  endtask

  task automatic fail_try();
    excitation_done = 1;
    step(2);
    repeat (2) begin
      forced_step = 1;
      step(1);
      forced_step = 0;
      step(3);
    end
    excitation_done = 0;
  endtask

  // rising edge at the start, so edge spacing equals len
  task automatic fb_period(input int len);
    position_u = 1;
    step(len / 2);
    position_u = 0;
    step(len - len / 2);
  endtask

  task automatic fb_short(input int k);
    repeat (k) begin
      rnd = lfsr_next(rnd);
      fb_period(20 + rnd[4:0]);
    end
  endtask

  // start, leave forced mode, then release feedback after nine steps
  task automatic run_up(input int lo, input int hi);
    forced_mode = 1;
    wait_start(lo, hi);
    excitation_done = 1;
    position_u = 1;
    step(4);
    forced_mode = 0;
    step(3);
    check(start_request, 0);
    check(all_off(), 0);
    repeat (9) begin
      check(rotation_feedback, 0);
      position_step = 1;
      step(1);
      position_step = 0;
      step(1);
    end
    step(3);
    check(rotation_feedback, 1);
  endtask

  initial begin
    int n;
    step(16);
    check(rotation_feedback, 0);
    reset = 0;
    run_request = 1;
    internal_chop_signal = 1;
    commutation = '{high_on: 3'h1, low_on: 3'h2};
    wait_start(0, 8);
    fail_try();
    step(4);
    check(start_request, 1);
    // acting as upstream controller: no feedback seen, restart by hand
    run_request = 0;
    step(2);
    check(start_request, 0);
    run_request = 1;
    step(8);
    check(start_request, 1);
    repeat (40) begin
      rnd = lfsr_next(rnd);
      internal_chop_signal = rnd[0];
      step(1);
      check(hg, 3'h6);
    end
    internal_chop_signal = 1;
    step(8);
    check(lg, 3'h2);
    // swap U and V between high and low conduction
    commutation = '{high_on: 3'h2, low_on: 3'h1};
    step(12);
    check({hg, lg}, 6'h29);
    direction_select = 1;
    n = 0;
    repeat (DOFF + 30) begin
      step(1);
      n += all_off();
    end
    check(n >= DOFF && n <= DOFF + DT + 4, 1);
    check({hg, lg}, 6'h29);
    analog_speed_command = 1;
    for (int i = 1; i <= 8; i++) begin
      fail_try();
      check(start_request, 0);
      check(motor_halted, i == 8);
      if (i < 8) wait_start(RW - 4, RW + 8);
    end
    step(RW + 20);
    check({start_request, all_off()}, 2'h1);
    disable_input = 1;
    step(3);
    check(motor_halted, 0);
    disable_input = 0;
    run_up(0, 8);
    // a period just over the full-duty limit clears the short-period run
    fb_short(5);
    fb_period(40100);
    fb_short(16);
    check(all_off(), 0);
    fb_period(20);
    step(3);
    check(all_off(), 1);
    check(rotation_feedback, 0);
    chop_full_duty = 0;
    run_up(RW - 24, RW - 18);
    fb_short(5);
    fb_period(40100);
    fb_short(10);
    check(all_off(), 0);
    fb_short(1);
    step(3);
    check(all_off(), 1);
    check(faults, 0);
    complete_run();
  end
endmodule // srgt_core_tb_top
